// >>> core/sgc_global_cfg.v
// Global configuration registers 0x0B to 0x0F with their decoded outputs.
// Assumes the serial interface hands over byte-wide single-cycle strobes.
`timescale 1ns/100ps
`include "sgc_consts.vh"
module sgc_global_cfg (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Register port from the serial interface
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    output reg reg_rvalid_ff,
    output reg reg_hit_ff,
    // Priority lookup for tagged frames
    input wire tag_vld,
    input wire [2:0] tag_pcp,
    output wire prio_vld,
    output wire [1:0] prio,
    // Unknown destination forwarding
    input wire unk_vld,
    output reg unk_vld_ff,
    output reg [2:0] unk_ports_ff,
    // Static configuration outputs
    output reg [1:0] host_clk_sel_ff,
    output reg [2:0] host_clk_ratio_ff,
    output reg drive_16ma_ff,
    output reg [4:0] phy1_addr_ff,
    output reg [4:0] phy2_addr_ff,
    output reg phy_addr_bad_ff
);
    reg [7:0] map_lo_ff;
    reg [7:0] map_hi_ff;
    reg unk_en_ff;
    reg [2:0] unk_mask_ff;
    reg [7:0] nxt_rdata;
    reg nxt_hit;
    reg [2:0] nxt_ratio;

    function is_bad_addr;
        input [4:0] a;
        begin
            is_bad_addr = (a == `SGC_PHY_ADDR_BAD0) ||
                (a == `SGC_PHY_ADDR_BAD1) || (a == `SGC_PHY_ADDR_BAD2);
        end
    endfunction

    // Writes land in one cycle so the next frame sees them
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            host_clk_sel_ff <= `SGC_CLK_SEL_RST;
            map_lo_ff <= `SGC_MAP_LO_RST;
            map_hi_ff <= `SGC_MAP_HI_RST;
            unk_en_ff <= `SGC_UNK_EN_RST;
            drive_16ma_ff <= `SGC_DRIVE_RST;
            unk_mask_ff <= `SGC_UNK_MASK_RST;
            phy1_addr_ff <= `SGC_PHY_ADDR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `SGC_OFS_CLK_SEL: host_clk_sel_ff <= reg_wdata[7:6];
                `SGC_OFS_MAP_LO: map_lo_ff <= reg_wdata;
                `SGC_OFS_MAP_HI: map_hi_ff <= reg_wdata;
                `SGC_OFS_UNK_FWD: begin
                    unk_en_ff <= reg_wdata[`SGC_UNK_EN_BIT];
                    drive_16ma_ff <= reg_wdata[`SGC_DRIVE_BIT];
                    unk_mask_ff <= reg_wdata[2:0];
                end
                `SGC_OFS_PHY_BASE: phy1_addr_ff <= reg_wdata[7:3];
                default: begin
                end
            endcase
        end
    end

    // Reserved fields read fixed values regardless of what was written
    always @* begin
        nxt_rdata = 8'h00;
        nxt_hit = 1'b1;
        case (reg_addr)
            `SGC_OFS_CLK_SEL: nxt_rdata = {host_clk_sel_ff,
                `SGC_CLK_SEL_RSV};
            `SGC_OFS_MAP_LO: nxt_rdata = map_lo_ff;
            `SGC_OFS_MAP_HI: nxt_rdata = map_hi_ff;
            `SGC_OFS_UNK_FWD: nxt_rdata = {unk_en_ff, drive_16ma_ff,
                3'h0, unk_mask_ff};
            `SGC_OFS_PHY_BASE: nxt_rdata = {phy1_addr_ff, 3'h0};
            default: nxt_hit = 1'b0;
        endcase
    end

    // Divide of the 125 MHz base: 1, 2 or 4; unused code falls back to 1
    always @* begin
        case (host_clk_sel_ff)
            `SGC_CLK_31M: nxt_ratio = 3'h4;
            `SGC_CLK_62M: nxt_ratio = 3'h2;
            `SGC_CLK_125M: nxt_ratio = 3'h1;
            default: nxt_ratio = 3'h1;
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
            reg_hit_ff <= 1'b0;
            unk_vld_ff <= 1'b0;
            unk_ports_ff <= 3'h0;
            host_clk_ratio_ff <= 3'h1;
            phy2_addr_ff <= 5'h02;
            phy_addr_bad_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
                reg_hit_ff <= nxt_hit;
            end
            unk_vld_ff <= unk_vld;
            // Disabled: all ports flood, as without the feature
            if (unk_vld) begin
                unk_ports_ff <= unk_en_ff ? unk_mask_ff : 3'h7;
            end
            host_clk_ratio_ff <= nxt_ratio;
            phy2_addr_ff <= phy1_addr_ff + 5'h01;
            phy_addr_bad_ff <= is_bad_addr(phy1_addr_ff);
        end
    end

    sgc_prio_lookup u_prio (
        .core_clk(core_clk),
        .rstn(rstn),
        .prio_map({map_hi_ff, map_lo_ff}),
        .tag_vld(tag_vld),
        .tag_pcp(tag_pcp),
        .prio_vld_ff(prio_vld),
        .prio_ff(prio)
    );
endmodule

// >>> core/sgc_consts.vh
// Register offsets, field positions and reset values for the global
// configuration bank. Assumes an 8-bit register port with byte offsets.
// What this block does
// - Clock select 00 picks the 31.25 MHz host interface clock rate.
// - Clock select 01 picks the 62.5 MHz host interface clock rate.
// - Clock select 10, bits 7-6 of offset 0x0B, picks 125 MHz; reset 10.
// - A tagged frame's priority is the two-bit map field its tag indexes.
// - Map resets to 00,00,01,01,10,10,11,11 for tags 0 through 7.
// - Bit 7 of 0x0E enables sending unknown frames to masked ports; reset 0.
// - Mask bits 2-0 of 0x0E include ports 3,2,1 when set; reset 111.
// - Bits 7-3 of 0x0F set first PHY address; 00000,11110,11111 invalid.
// - The second PHY address is the first PHY address plus one.
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
`define SGC_OFS_CLK_SEL 8'h0B
`define SGC_OFS_MAP_LO 8'h0C
`define SGC_OFS_MAP_HI 8'h0D
`define SGC_OFS_UNK_FWD 8'h0E
`define SGC_OFS_PHY_BASE 8'h0F
`define SGC_CLK_SEL_RST 2'h2
`define SGC_CLK_31M 2'h0
`define SGC_CLK_62M 2'h1
`define SGC_CLK_125M 2'h2
`define SGC_CLK_SEL_RSV 6'h08
`define SGC_MAP_LO_RST 8'h50
`define SGC_MAP_HI_RST 8'hFA
`define SGC_UNK_EN_BIT 7
`define SGC_DRIVE_BIT 6
`define SGC_UNK_EN_RST 1'h0
`define SGC_DRIVE_RST 1'h1
`define SGC_UNK_MASK_RST 3'h7
`define SGC_PHY_ADDR_RST 5'h01
`define SGC_PHY_ADDR_BAD0 5'h00
`define SGC_PHY_ADDR_BAD1 5'h1E
`define SGC_PHY_ADDR_BAD2 5'h1F
`endif

// >>> core/sgc_prio_lookup.v
// Registered 802.1p tag to priority lookup.
// Assumes the map bytes come straight from the register bank.
`timescale 1ns/100ps
module sgc_prio_lookup (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Map and request
    input wire [15:0] prio_map,
    input wire tag_vld,
    input wire [2:0] tag_pcp,
    // Result
    output reg prio_vld_ff,
    output reg [1:0] prio_ff
);
    wire [1:0] nxt_prio;
    // Fields pack from bit 0 upward, two bits per tag
    assign nxt_prio = prio_map[{tag_pcp, 1'b0} +: 2];

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prio_vld_ff <= 1'b0;
            prio_ff <= 2'h0;
        end else begin
            prio_vld_ff <= tag_vld;
            if (tag_vld) begin
                prio_ff <= nxt_prio;
            end
        end
    end
endmodule

// >>> test/sgc_host_model.sv
// Host side of the register port.
// Assumes single byte accesses answered one cycle later.
`timescale 1ns/100ps
module sgc_host_model (
    input wire core_clk, input wire [7:0] reg_rdata_ff,
    input wire reg_rvalid_ff, output logic reg_wr, output logic reg_rd,
    output logic [7:0] reg_addr, output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge core_clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge core_clk) #1;
        // Idle lines show inverted leftovers so stale data never matches
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
        q = reg_rvalid_ff ? reg_rdata_ff : 8'hXX;
    endtask
endmodule

// >>> test/sgc_mon_monitor.sv
// Port checks for the configuration bank.
// Assumes binding into sgc_global_cfg.
`timescale 1ns/100ps
`include "sgc_consts.vh"
module sgc_mon (
    input wire core_clk, input wire rstn, input wire reg_rd,
    input wire reg_wr, input wire [7:0] reg_addr, input wire tag_vld,
    input wire [7:0] reg_wdata,
    input wire unk_vld, input wire reg_rvalid_ff, input wire prio_vld,
    input wire [1:0] prio, input wire unk_vld_ff, input wire drive_16ma_ff,
    input wire [1:0] host_clk_sel_ff, input wire [2:0] host_clk_ratio_ff,
    input wire [4:0] phy1_addr_ff, input wire [4:0] phy2_addr_ff,
    input wire phy_addr_bad_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_drv_wr;
        reg_wr && reg_addr == `SGC_OFS_UNK_FWD;
    endsequence
    AST_RVALID: assert property (reg_rvalid_ff == $past(reg_rd))
        else $error("read answer timing");
    AST_PRIO_VLD: assert property (prio_vld == $past(tag_vld))
        else $error("priority answer timing");
    AST_PRIO_HOLD: assert property (!tag_vld |=> $stable(prio))
        else $error("priority moved alone");
    AST_UNK_VLD: assert property (unk_vld_ff == $past(unk_vld))
        else $error("unknown answer timing");
    AST_DRIVE: assert property (
        !(reg_wr && reg_addr == `SGC_OFS_UNK_FWD) |=>
        $stable(drive_16ma_ff))
        else $error("drive moved alone");
    AST_DRIVE_WR: assert property (
        s_drv_wr |=> drive_16ma_ff == $past(reg_wdata[6]))
        else $error("drive write lost");
    AST_PHY2: assert property (
        phy2_addr_ff == $past(phy1_addr_ff) + 5'h01)
        else $error("second address wrong");
    AST_BAD: assert property (phy_addr_bad_ff ==
        ($past(phy1_addr_ff) inside {5'h00, 5'h1E, 5'h1F}))
        else $error("bad flag wrong");
    AST_RATIO: assert property (host_clk_ratio_ff ==
        ($past(host_clk_sel_ff) == 2'h0 ? 3'h4 :
        $past(host_clk_sel_ff) == 2'h1 ? 3'h2 : 3'h1))
        else $error("ratio wrong");
endmodule
bind sgc_global_cfg sgc_mon sgc_mon_i (.*);

// >>> test/switch_global_config_regs_bench.sv
// Directed bench for the configuration bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module switch_global_config_regs_bench;
    logic core_clk = 0, rstn = 0, tag_vld = 0, unk_vld = 0;
    logic [2:0] tag_pcp = 0, unk_ports_ff, host_clk_ratio_ff;
    logic reg_wr, reg_rd, reg_rvalid_ff, reg_hit_ff, prio_vld, unk_vld_ff;
    logic drive_16ma_ff, phy_addr_bad_ff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, q;
    logic [1:0] prio, host_clk_sel_ff;
    logic [4:0] phy1_addr_ff, phy2_addr_ff;
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0] ra [6] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
    logic [7:0] rv [6] = '{8'h88, 8'h50, 8'hFA, 8'h47, 8'h08, 8'h00};
    sgc_global_cfg sgc_global_cfg_i (.*);
    sgc_host_model sgc_host_model_i (.*);
    task rd(input logic [7:0] a, e);
        sgc_host_model_i.xfer(0, a, 8'h00, q);
        `CHK("rdata", e, q)
    endtask
    task wr(input logic [7:0] a, d);
        sgc_host_model_i.xfer(1, a, d, q);
    endtask
    task pulse(input logic [2:0] t);
        @(posedge core_clk) #1;
        {tag_vld, unk_vld, tag_pcp} = {2'h3, t};
        @(posedge core_clk) #1;
        {tag_vld, unk_vld} = 2'h0;
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 3000) begin
        errors++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        #1 rstn = 1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rv[i]);
            `CHK("hit", i < 5, reg_hit_ff)
        end
        $display("reset test done");
        for (int s = 0; s < 3; s++) begin
            wr(8'h0B, {s[1:0], 6'h37});
            rd(8'h0B, {s[1:0], 6'h08});
            `CHK("ratio", 3'h4 >> s, host_clk_ratio_ff)
        end
        wr(8'h0B, 8'h08);
        $display("clock test done");
        wr(8'h0C, 8'h1B);
        wr(8'h0D, 8'hE4);
        for (int t = 0; t < 8; t++) begin
            pulse(t[2:0]);
            `CHK("prio", 2'(16'hE41B >> 2 * t), prio)
            `CHK("ports", 3'h7, unk_ports_ff)
        end
        wr(8'h0E, 8'hBD);
        rd(8'h0E, 8'h85);
        pulse(3'h0);
        `CHK("ports", 3'h5, unk_ports_ff)
        `CHK("drive", 1'b0, drive_16ma_ff)
        $display("frame test done");
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'hF8);
        `CHK("phy2", 5'h00, phy2_addr_ff)
        `CHK("bad", 1'b1, phy_addr_bad_ff)
        $display("address test done");
        give_verdict();
    end
endmodule
